/* core/oas_core.sv */
// operand address generation and stack pointer selection
// Contract
// - alu takes register operands only; memory moves via load and store
// - bit operations may address memory operands directly
// - lower-numbered register of a pair holds the low half
// - short mode clear: index bases, return address, stack pointer are pairs
// - byte operations write only the low byte of the destination
// - immediate operand comes from the instruction, no access
// - relative address is displacement plus pc, register or pair
// - branch target is always pc plus displacement
// - address formation never alters the base register
// - double load: high word to higher register, low word to lower
// - index mode uses an index base and needs short mode clear
// - index relative: base plus pair plus 14 or 20 bit unsigned displacement
// - index absolute: base plus 20 bit absolute field
// - absolute address comes straight from instruction field
// - stacks grow downward on push
// - exception entry pushes state; return pops it
// - exception stack has its own pointer
// - only push, pop and pop-return change the program stack pointer
// - user flag clear selects supervisor pointer, set selects user pointer
// - only jump-to-user sets the user flag; exception return also sets it when the flag saved at entry was set
// - exception clears user mode; return restores it
// - long processor register load blocked in user mode
// - reset clears status bits 0..11 except interrupt enable
// - reset clears configuration including short mode bit
module oas_core
  import oas_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  // operand request
  input wire logic REQ,
  input wire logic [2:0] MODE,
  input wire logic BIT_OP,
  input wire logic ALU_OP,
  input wire logic BYTE_OP,
  input wire logic DISP_LONG,
  input wire logic [1:0] IDX_SEL,
  input wire logic [31:0] PC,
  input wire logic [15:0] REG_VAL,
  input wire logic [15:0] PAIR_LO,
  input wire logic [15:0] PAIR_HI,
  input wire logic [15:0] DEST_OLD,
  input wire logic [15:0] ALU_RESULT,
  input wire logic [31:0] IMM,
  input wire logic [23:0] DISP,
  input wire logic [23:0] ABS_ADDR,
  // load data returning
  input wire logic LOAD_VALID,
  input wire logic [31:0] LOAD_DATA,
  // stack and mode control
  input wire logic PUSH_OP,
  input wire logic POP_OP,
  input wire logic POP_AND_RETURN_OP_OP,
  input wire logic JUMP_TO_USER,
  input wire logic EXC_TAKE,
  input wire logic EXC_RET,
  input wire logic LONG_PREG_LOAD,
  input wire logic [15:0] PREG_DATA,
  input wire logic CFG_WR,
  input wire logic SHORT_REG_MODE_IN,
  input wire logic [31:0] IDX_BASE0,
  input wire logic [31:0] IDX_BASE1,
  // results
  output logic ADDR_VALID,
  output logic [31:0] ADDR,
  output logic MEM_ACCESS,
  output logic OPERAND_VALID,
  output logic [31:0] OPERAND,
  output logic [15:0] BYTE_WB,
  output logic [15:0] WB_LO,
  output logic [15:0] WB_HI,
  output logic WB_VALID,
  output logic MODE_ERR,
  output logic PREG_BLOCKED,
  output logic [31:0] PROG_SP,
  output logic [31:0] SUPERVISOR_STACK_POINTER,
  output logic [31:0] USER_PROGRAM_STACK_POINTER,
  output logic [31:0] EXCEPTION_STACK_POINTER,
  output logic [15:0] PROCESSOR_STATUS_WORD,
  output logic SHORT_REGISTER_MODE_BIT,
  output logic STACK_BUSY
);

  // ----------------------------------------------------------------
  // pair assembly
  // ----------------------------------------------------------------
  oas_pair_if pair_bus ();
  assign pair_bus.lo_word = PAIR_LO;
  assign pair_bus.hi_word = PAIR_HI;
  oas_pair_asm u_pair (.p(pair_bus.asm));

  logic [31:0] pair_val;
  assign pair_val = pair_bus.pair;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [15:0] psw_ff;
  logic short_mode_ff;
  logic saved_user_ff;
  logic [31:0] ssp_ff;
  logic [31:0] usp_ff;
  logic [31:0] esp_ff;
  oas_state_e state_ff;
  oas_state_e nxt_state;
  logic user_mode_flag;
  assign user_mode_flag = psw_ff[PSW_U_BIT];

  // ----------------------------------------------------------------
  // effective address
  // ----------------------------------------------------------------
  logic [31:0] nxt_addr;
  logic nxt_mem;
  logic nxt_err;
  logic nxt_opv;
  logic [31:0] idx_base;
  logic [31:0] idx_disp;
  oas_mode_e mode_q;
  assign mode_q = oas_mode_e'(MODE);
  // base registers are only read here, so they are never altered
  assign idx_base = IDX_SEL[0] ? IDX_BASE1 : IDX_BASE0;

  always_comb
  begin
    // unsigned field, width picked by the instruction
    idx_disp = DISP_LONG ? {12'h000, DISP[DISP_LONG_W-1:0]}
                         : {18'h0_0000, DISP[DISP_SHORT_W-1:0]};
  end

  always_comb
  begin
    nxt_addr = 32'h0000_0000;
    nxt_mem = 1'b0;
    nxt_err = 1'b0;
    nxt_opv = 1'b0;
    case (mode_q)
      MODE_REG:
      begin
        nxt_opv = 1'b1;
      end
      MODE_IMM:
      begin
        nxt_opv = 1'b1;
      end
      MODE_REL_PC:
      begin
        nxt_addr = PC + {{8{DISP[23]}}, DISP};
        nxt_mem = 1'b1;
      end
      MODE_REL_REG:
      begin
        nxt_addr = {16'h0000, REG_VAL} + {{8{DISP[23]}}, DISP};
        nxt_mem = 1'b1;
      end
      MODE_REL_PAIR:
      begin
        nxt_addr = pair_val + {{8{DISP[23]}}, DISP};
        nxt_mem = 1'b1;
      end
      MODE_ABS:
      begin
        nxt_addr = {8'h00, ABS_ADDR};
        nxt_mem = 1'b1;
      end
      MODE_IDX_REL:
      begin
        nxt_addr = idx_base + pair_val + idx_disp;
        nxt_mem = !short_mode_ff;
        nxt_err = short_mode_ff;
      end
      MODE_IDX_ABS:
      begin
        nxt_addr = idx_base + {12'h000, ABS_ADDR[ABS_INDEX_W-1:0]};
        nxt_mem = !short_mode_ff;
        nxt_err = short_mode_ff;
      end
      default:
      begin
        nxt_err = 1'b1;
      end
    endcase
    // arithmetic never reaches memory; bit operations may
    if (ALU_OP && !BIT_OP && nxt_mem)
    begin
      nxt_mem = 1'b0;
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ADDR_VALID <= 1'b0;
      ADDR <= 32'h0000_0000;
      MEM_ACCESS <= 1'b0;
      MODE_ERR <= 1'b0;
      OPERAND_VALID <= 1'b0;
      OPERAND <= 32'h0000_0000;
    end
    else if (CE)
    begin
      ADDR_VALID <= REQ && nxt_mem;
      ADDR <= nxt_addr;
      MEM_ACCESS <= REQ && nxt_mem;
      MODE_ERR <= REQ && nxt_err;
      OPERAND_VALID <= REQ && nxt_opv;
      OPERAND <= (mode_q == MODE_IMM) ? IMM : pair_val;
    end
  end

  // ----------------------------------------------------------------
  // write-back shaping
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      BYTE_WB <= 16'h0000;
      WB_LO <= 16'h0000;
      WB_HI <= 16'h0000;
      WB_VALID <= 1'b0;
    end
    else if (CE)
    begin
      BYTE_WB <= BYTE_OP ? {DEST_OLD[15:8], ALU_RESULT[7:0]} : ALU_RESULT;
      WB_VALID <= LOAD_VALID;
      if (LOAD_VALID)
      begin
        WB_LO <= LOAD_DATA[15:0];
        WB_HI <= LOAD_DATA[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration and status word
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      short_mode_ff <= 1'b0;
    else if (CE && CFG_WR)
      short_mode_ff <= SHORT_REG_MODE_IN;
  end

  logic preg_ok;
  // user mode cannot rewrite processor registers
  assign preg_ok = LONG_PREG_LOAD && !user_mode_flag;

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      psw_ff <= PSW_RESET;
      saved_user_ff <= 1'b0;
    end
    else if (CE)
    begin
      // exception taken in the run state has priority: it leaves user mode whatever else happens
      if (EXC_TAKE && state_ff == ST_RUN)
      begin
        saved_user_ff <= user_mode_flag;
        psw_ff[PSW_U_BIT] <= 1'b0;
      end
      else if (EXC_RET && state_ff == ST_RUN)
        psw_ff[PSW_U_BIT] <= saved_user_ff;
      else if (JUMP_TO_USER)
        psw_ff[PSW_U_BIT] <= 1'b1;
      // user flag is kept as is: a processor register load never changes it
      else if (preg_ok)
        psw_ff <= {4'h0, PREG_DATA[11:8], user_mode_flag, PREG_DATA[6:0]};
    end
  end

  // ----------------------------------------------------------------
  // exception stack sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    case (state_ff)
      ST_RUN:
      begin
        if (EXC_TAKE)
          nxt_state = ST_EXC_PUSH;
        else if (EXC_RET)
          nxt_state = ST_RET_POP;
        else
          nxt_state = ST_RUN;
      end
      ST_EXC_PUSH: nxt_state = ST_RUN;
      ST_RET_POP: nxt_state = ST_RUN;
      default: nxt_state = ST_RUN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      state_ff <= ST_RUN;
    else if (CE)
      state_ff <= nxt_state;
  end

  // separate pointer; frame of pc and status word moves it down then back up
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      esp_ff <= SP_RESET;
    else if (CE)
    begin
      if (state_ff == ST_EXC_PUSH)
        esp_ff <= esp_ff - FRAME_STEP;
      else if (state_ff == ST_RET_POP)
        esp_ff <= esp_ff + FRAME_STEP;
    end
  end

  // ----------------------------------------------------------------
  // program stack pointers
  // ----------------------------------------------------------------
  logic [31:0] sel_sp;
  logic sp_dec;
  logic sp_inc;
  assign sel_sp = user_mode_flag ? usp_ff : ssp_ff;
  // only these three operations touch the program stack
  assign sp_dec = PUSH_OP;
  assign sp_inc = POP_OP || POP_AND_RETURN_OP_OP;

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ssp_ff <= SP_RESET;
      usp_ff <= SP_RESET;
    end
    else if (CE && state_ff == ST_RUN)
    begin
      if (sp_dec)
      begin
        if (user_mode_flag)
          usp_ff <= usp_ff - STACK_STEP;
        else
          ssp_ff <= ssp_ff - STACK_STEP;
      end
      else if (sp_inc)
      begin
        if (user_mode_flag)
          usp_ff <= usp_ff + STACK_STEP;
        else
          ssp_ff <= ssp_ff + STACK_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PROG_SP <= SP_RESET;
      SUPERVISOR_STACK_POINTER <= SP_RESET;
      USER_PROGRAM_STACK_POINTER <= SP_RESET;
      EXCEPTION_STACK_POINTER <= SP_RESET;
      PROCESSOR_STATUS_WORD <= PSW_RESET;
      SHORT_REGISTER_MODE_BIT <= 1'b0;
      STACK_BUSY <= 1'b0;
      PREG_BLOCKED <= 1'b0;
    end
    else if (CE)
    begin
      PROG_SP <= sel_sp;
      SUPERVISOR_STACK_POINTER <= ssp_ff;
      USER_PROGRAM_STACK_POINTER <= usp_ff;
      EXCEPTION_STACK_POINTER <= esp_ff;
      PROCESSOR_STATUS_WORD <= psw_ff;
      SHORT_REGISTER_MODE_BIT <= short_mode_ff;
      STACK_BUSY <= (nxt_state != ST_RUN);
      PREG_BLOCKED <= LONG_PREG_LOAD && user_mode_flag;
    end
  end
endmodule : oas_core

/* core/oas_pair_asm.sv */
// pair assembler: joins two 16-bit registers into one 32-bit value
module oas_pair_asm
  import oas_pkg::*;
(
  oas_pair_if.asm p
);
  // lower-numbered register is the low half
  assign p.pair = {p.hi_word, p.lo_word};
endmodule : oas_pair_asm

/* core/oas_pair_if.sv */
// interface: register pair carried to the pair assembler
interface oas_pair_if;
  logic [15:0] lo_word;
  logic [15:0] hi_word;
  logic [31:0] pair;
  modport src (output lo_word, output hi_word, input pair);
  modport asm (input lo_word, input hi_word, output pair);
endinterface : oas_pair_if

/* core/oas_pkg.sv */
// package: operand addressing and stack constants
package oas_pkg;
  localparam int AW = 32;
  localparam int DW = 16;
  localparam logic [15:0] PSW_RESET = 16'h0040;
  localparam int PSW_U_BIT = 7;
  localparam int PSW_E_BIT = 6;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;
  localparam logic [31:0] STACK_STEP = 32'h0000_0002;
  localparam logic [31:0] FRAME_STEP = 32'h0000_0004;
  localparam int DISP_SHORT_W = 14;
  localparam int DISP_LONG_W = 20;
  localparam int ABS_INDEX_W = 20;

  typedef enum logic [2:0]
  {
    MODE_REG = 3'b000,
    MODE_IMM = 3'b001,
    MODE_REL_PC = 3'b010,
    MODE_REL_REG = 3'b011,
    MODE_REL_PAIR = 3'b100,
    MODE_ABS = 3'b101,
    MODE_IDX_REL = 3'b110,
    MODE_IDX_ABS = 3'b111
  } oas_mode_e;

  typedef enum logic [1:0]
  {
    ST_RUN = 2'b00,
    ST_EXC_PUSH = 2'b01,
    ST_RET_POP = 2'b10
  } oas_state_e;
endpackage : oas_pkg

/* verification/oas_core_sva.sv */
// checker: port-level properties of the operand address core
module oas_core_sva
  import oas_pkg::*;
(
  // clock, reset and requests
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic REQ,
  input wire logic ALU_OP,
  input wire logic BIT_OP,
  input wire logic [2:0] MODE,
  input wire logic [1:0] IDX_SEL,
  input wire logic [31:0] PC,
  input wire logic [23:0] DISP,
  input wire logic [23:0] ABS_ADDR,
  input wire logic [31:0] IDX_BASE0,
  input wire logic [31:0] IDX_BASE1,
  input wire logic LOAD_VALID,
  input wire logic [31:0] LOAD_DATA,
  input wire logic EXC_TAKE,
  // results
  input wire logic ADDR_VALID,
  input wire logic [31:0] ADDR,
  input wire logic MEM_ACCESS,
  input wire logic [15:0] WB_LO,
  input wire logic [15:0] WB_HI,
  input wire logic WB_VALID,
  input wire logic MODE_ERR,
  input wire logic [31:0] PROG_SP,
  input wire logic [31:0] SUPERVISOR_STACK_POINTER,
  input wire logic [31:0] USER_PROGRAM_STACK_POINTER,
  input wire logic [15:0] PROCESSOR_STATUS_WORD,
  input wire logic SHORT_REGISTER_MODE_BIT
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  wire logic [31:0] base = IDX_SEL[0] ? IDX_BASE1 : IDX_BASE0;
  wire logic [31:0] rel_exp = PC + {{8{DISP[23]}}, DISP};
  wire logic [31:0] iabs_exp = base + {12'h000, ABS_ADDR[19:0]};
  wire logic idx_req = CE && REQ && MODE[2:1] == 2'b11;
  rel_pc_a: assert property (CE && REQ && MODE == MODE_REL_PC && !(ALU_OP && !BIT_OP) |=>
    ADDR_VALID && ADDR == $past(rel_exp)) else $error("pc relative address wrong");
  abs_addr_a: assert property (CE && REQ && MODE == MODE_ABS |=> ADDR == {8'h00, $past(ABS_ADDR)}) else $error("absolute address wrong");
  idx_abs_a: assert property (idx_req && MODE[0] && !SHORT_REGISTER_MODE_BIT |=> ADDR == $past(iabs_exp)) else $error("index absolute address wrong");
  idx_refuse_a: assert property (idx_req && SHORT_REGISTER_MODE_BIT |=> MODE_ERR && !MEM_ACCESS) else $error("index mode not refused");
  load_pair_a: assert property (CE && LOAD_VALID |=> WB_VALID && {WB_HI, WB_LO} == $past(LOAD_DATA)) else $error("load halves misplaced");
  sp_select_a: assert property (PROG_SP == (PROCESSOR_STATUS_WORD[PSW_U_BIT] ? USER_PROGRAM_STACK_POINTER : SUPERVISOR_STACK_POINTER)) else $error("wrong program pointer");
  reset_psw_a: assert property ($rose(RSTN) |-> PROCESSOR_STATUS_WORD == PSW_RESET && !SHORT_REGISTER_MODE_BIT) else $error("reset state wrong");
  exc_user_a: assert property (CE && EXC_TAKE ##1 CE |=> !PROCESSOR_STATUS_WORD[PSW_U_BIT]) else $error("user mode kept");
endmodule : oas_core_sva
bind oas_core oas_core_sva u_sva (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE), .REQ(REQ),
  .ALU_OP(ALU_OP), .BIT_OP(BIT_OP), .MODE(MODE),
  .IDX_SEL(IDX_SEL), .PC(PC), .DISP(DISP), .ABS_ADDR(ABS_ADDR), .IDX_BASE0(IDX_BASE0),
  .IDX_BASE1(IDX_BASE1), .LOAD_VALID(LOAD_VALID), .LOAD_DATA(LOAD_DATA), .EXC_TAKE(EXC_TAKE),
  .ADDR_VALID(ADDR_VALID), .ADDR(ADDR), .MEM_ACCESS(MEM_ACCESS), .WB_LO(WB_LO), .WB_HI(WB_HI),
  .WB_VALID(WB_VALID), .MODE_ERR(MODE_ERR), .PROG_SP(PROG_SP),
  .SUPERVISOR_STACK_POINTER(SUPERVISOR_STACK_POINTER),
  .USER_PROGRAM_STACK_POINTER(USER_PROGRAM_STACK_POINTER),
  .PROCESSOR_STATUS_WORD(PROCESSOR_STATUS_WORD), .SHORT_REGISTER_MODE_BIT(SHORT_REGISTER_MODE_BIT));

/* verification/oas_mem_model.sv */
// partner: memory answering load accesses, promptly or after a wait
module oas_mem_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // load bus
  input wire logic mem_access,
  input wire logic [31:0] addr,
  output logic load_valid,
  output logic [31:0] load_data
);
  // ----------------------------------------
  // answer engine
  // ----------------------------------------
  logic [1:0] wait_ff;
  logic [31:0] addr_ff;
  // idle data toggles so a stale word is never mistaken for an answer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_ff <= 2'd0;
      addr_ff <= 32'h0000_0000;
      load_valid <= 1'b0;
      load_data <= 32'h0000_0000;
    end
    else
    begin
      load_valid <= wait_ff == 2'd1;
      load_data <= wait_ff == 2'd1 ? {addr_ff[15:0], ~addr_ff[31:16]} : ~load_data;
      if (mem_access)
        addr_ff <= addr;
      if (mem_access)
        wait_ff <= addr[1] ? 2'd3 : 2'd1;
      else if (wait_ff != 2'd0)
        wait_ff <= wait_ff - 2'd1;
    end
  end
endmodule : oas_mem_model

/* verification/tb_cpu_operand_addressing_and_stacks.sv */
// testbench: operand addressing and stack core
module tb_cpu_operand_addressing_and_stacks
  import oas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, ce, req, bit_op, dl, lv, sri, mem, merr, srm, short_exp;
  logic alu, byt, opv, pb, busy, pb_seen, busy_seen;
  logic [2:0] mode;
  logic [1:0] isel;
  logic [7:0] stb;
  logic [15:0] rv, plo, phi, dold, ares, preg, psw, p, bwb;
  logic [23:0] disp, absa;
  logic [31:0] pc, imm, ld, b0, b1, addr, opnd, psp, ssp, user_program_stack_pointer, xsp;
  int seed = 32'h5851;
  int error_cnt = 0;
  int n_tests = 0;
  oas_core uut (.CLOCK(clk), .RSTN(rstn), .CE(ce), .REQ(req), .MODE(mode), .BIT_OP(bit_op),
    .ALU_OP(alu), .BYTE_OP(byt), .DISP_LONG(dl), .IDX_SEL(isel), .PC(pc), .REG_VAL(rv),
    .PAIR_LO(plo), .PAIR_HI(phi), .DEST_OLD(dold), .ALU_RESULT(ares), .IMM(imm), .DISP(disp),
    .ABS_ADDR(absa), .LOAD_VALID(lv), .LOAD_DATA(ld), .PUSH_OP(stb[0]), .POP_OP(stb[1]),
    .POP_AND_RETURN_OP_OP(stb[2]), .JUMP_TO_USER(stb[3]), .EXC_TAKE(stb[4]), .EXC_RET(stb[5]),
    .LONG_PREG_LOAD(stb[6]), .PREG_DATA(preg), .CFG_WR(stb[7]), .SHORT_REG_MODE_IN(sri),
    .IDX_BASE0(b0), .IDX_BASE1(b1), .ADDR_VALID(), .ADDR(addr), .MEM_ACCESS(mem),
    .OPERAND_VALID(opv), .OPERAND(opnd), .BYTE_WB(bwb), .WB_LO(), .WB_HI(), .WB_VALID(),
    .MODE_ERR(merr), .PREG_BLOCKED(pb), .PROG_SP(psp), .SUPERVISOR_STACK_POINTER(ssp),
    .USER_PROGRAM_STACK_POINTER(user_program_stack_pointer), .EXCEPTION_STACK_POINTER(xsp),
    .PROCESSOR_STATUS_WORD(psw), .SHORT_REGISTER_MODE_BIT(srm), .STACK_BUSY(busy));
  oas_mem_model mem_model (.clk(clk), .rstn(rstn), .mem_access(mem), .addr(addr),
    .load_valid(lv), .load_data(ld));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] exp_addr();
    logic [31:0] b;
    logic [31:0] sd;
    b = isel[0] ? b1 : b0;
    sd = {{8{disp[23]}}, disp};
    case (mode)
      MODE_REG: return {phi, plo};
      MODE_IMM: return imm;
      MODE_REL_PC: return pc + sd;
      MODE_REL_REG: return {16'h0000, rv} + sd;
      MODE_REL_PAIR: return {phi, plo} + sd;
      MODE_ABS: return {8'h00, absa};
      MODE_IDX_ABS: return b + {12'h000, absa[19:0]};
      default: return b + {phi, plo} + (dl ? {12'h000, disp[19:0]} : {18'h0_0000, disp[13:0]});
    endcase
  endfunction : exp_addr
  // wrap forces pc near the top of the address space
  task automatic addr_op(input logic [2:0] m, input logic wrap);
    logic [31:0] e;
    logic err;
    @(posedge clk);
    req <= 1'b1;
    mode <= m;
    bit_op <= 1'($random(seed));
    alu <= 1'($random(seed));
    byt <= 1'($random(seed));
    dl <= 1'($random(seed));
    isel <= 2'($random(seed));
    pc <= wrap ? 32'hFFFF_FFF0 : $random(seed);
    disp <= wrap ? 24'h00_0020 : 24'($random(seed));
    {rv, plo, phi, dold, ares, imm, absa, b0, b1} <= 200'({$random(seed), $random(seed),
      $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
    @(posedge clk);
    req <= 1'b0;
    e = exp_addr();
    @(negedge clk);
    err = (m[2:1] == 2'b11 && short_exp) || (alu && !bit_op && m > MODE_IMM);
    chk({31'h0, merr}, {31'h0, err}, "refusal");
    chk({31'h0, mem}, {31'h0, m > MODE_IMM && !err}, "memory access");
    chk({31'h0, opv}, {31'h0, m <= MODE_IMM}, "operand valid");
    chk({16'h0000, bwb}, {16'h0000, byt ? {dold[15:8], ares[7:0]} : ares}, "byte");
    if (m <= MODE_IMM)
      chk(opnd, e, "operand");
    else if (!(m[2:1] == 2'b11 && short_exp))
      chk(addr, e, "address");
  endtask : addr_op
  task automatic strobe(input logic [7:0] v, input logic s);
    @(posedge clk);
    stb <= v;
    sri <= s;
    @(posedge clk);
    stb <= 8'h00;
    @(negedge clk);
    pb_seen = pb;
    busy_seen = busy;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : strobe
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    {rstn, req, bit_op, alu, byt, dl, sri, short_exp, mode, isel, stb} = '0;
    {ce, rv, plo, phi, dold, ares, preg, disp, absa, pc, imm, b0, b1} = {1'b1, 272'h0};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk({16'h0000, psw}, {16'h0000, PSW_RESET}, "psw reset");
    chk({31'h0, srm}, 32'h0000_0000, "config reset");
    for (int i = 0; i < 60; i++)
      addr_op(3'($unsigned($random(seed)) % 8), 1'b0);
    addr_op(MODE_REL_PC, 1'b1);
    strobe(8'h80, 1'b1);
    short_exp = 1'b1;
    addr_op(MODE_IDX_REL, 1'b0);
    addr_op(MODE_IDX_ABS, 1'b0);
    strobe(8'h80, 1'b0);
    short_exp = 1'b0;
    addr_op(MODE_IDX_REL, 1'b0);
    $display("address modes done");
    strobe(8'h01, 1'b0);
    strobe(8'h01, 1'b0);
    chk(psp, SP_RESET - STACK_STEP - STACK_STEP, "push");
    strobe(8'h02, 1'b0);
    chk(psp, SP_RESET - STACK_STEP, "pop");
    strobe(8'h04, 1'b0);
    chk(psp, SP_RESET, "pop return");
    ce <= 1'b0;
    strobe(8'h01, 1'b0);
    ce <= 1'b1;
    chk(psp, SP_RESET, "push with enable low");
    preg <= 16'hFFFF;
    strobe(8'h40, 1'b0);
    chk({16'h0000, psw}, 32'h0000_0F7F, "supervisor load");
    chk({31'h0, pb_seen}, 32'h0000_0000, "load allowed");
    strobe(8'h08, 1'b0);
    chk({31'h0, psw[PSW_U_BIT]}, 32'h0000_0001, "enter user");
    strobe(8'h01, 1'b0);
    chk(user_program_stack_pointer, SP_RESET - STACK_STEP, "user push");
    chk(ssp, SP_RESET, "supervisor kept");
    p = psw;
    preg <= ~p;
    strobe(8'h40, 1'b0);
    chk({16'h0000, psw}, {16'h0000, p}, "load blocked");
    chk({31'h0, pb_seen}, 32'h0000_0001, "blocked pulse");
    strobe(8'h10, 1'b0);
    chk({31'h0, psw[PSW_U_BIT]}, 32'h0000_0000, "exception leaves user");
    chk(xsp, SP_RESET - FRAME_STEP, "frame pushed");
    chk({31'h0, busy_seen}, 32'h0000_0001, "stack busy");
    strobe(8'h20, 1'b0);
    chk({31'h0, psw[PSW_U_BIT]}, 32'h0000_0001, "user restored");
    chk(xsp, SP_RESET, "frame popped");
    $display("stack tests done");
    strobe(8'h80, 1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk({16'h0000, psw}, {16'h0000, PSW_RESET}, "psw second reset");
    chk({31'h0, srm}, 32'h0000_0000, "config second reset");
    chk(psp, SP_RESET, "pointer second reset");
    addr_op(MODE_IDX_REL, 1'b0);
    $display("second reset done");
    wrap_up();
  end
endmodule : tb_cpu_operand_addressing_and_stacks
